// ===== hw/sdcad_dev.sv
// device end: samples strobes and address, decodes commands, tracks banks
// assumes the controller keeps bank ordering and drives pins synchronously
`timescale 1ns/1ns

// Behaviour
// R1 - sample all inputs on rising clock
// R2 - bank lines pick one of four banks
// R3 - open row captures twelve address bits
// R4 - column taken from eight low bits
// R5 - bit ten requests auto precharge on access
// R6 - precharge bit ten high closes all banks
// R7 - mode set loads op-code from address
// R8 - select high masks every command
// R9 - controller uses select per device
// R10 - decode row, column, write strobes
// R11 - row low alone opens bank
// R12 - row and write low precharge bank
// R13 - column low starts read or write
// R14 - write strobe low writes, high reads
// R15 - controller respects bank active/idle ordering; sdcad_ctrl forwards requests unchecked and relies on the user for it
module sdcad_dev
  import sdcad_pkg::*;
(
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // pins from controller
  sdcad_if.dev                       pins,
  // decoded command
  output logic                       o_cmd_vld,
  output sdcad_cmd_t                 o_cmd,
  output logic [BANK_W-1:0]          o_bank,
  output logic [ADDR_W-1:0]          o_row,
  output logic [COL_W-1:0]           o_col,
  output logic                       o_auto_pre,
  output logic                       o_pre_all,
  // mode op-code and bank states
  output logic [ADDR_W-1:0]          o_mode_op,
  output logic [NUM_BANKS-1:0]       o_bank_active,
  output logic [NUM_BANKS-1:0]       o_bank_idle
);

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  sdcad_cmd_t          cmd_nxt;        // decoded pin command
  sdcad_bank_t         bst_r [NUM_BANKS]; // per-bank state
  logic [1:0]          pcnt_r [NUM_BANKS]; // precharge countdown

  // combinational decode of the strobes
  always_comb
  begin
    // a deselected device decodes nothing, so the default comes first
    cmd_nxt = SDCAD_NOP;
    // R8 select masks
    if (!pins.sel_n)
    begin
      // R10 strobe combination
      unique case ({pins.row_stb_n, pins.col_stb_n, pins.wr_stb_n})
        // R11 open row
        3'h3:    cmd_nxt = SDCAD_OPEN;
        // R12 precharge decode
        3'h2:    cmd_nxt = SDCAD_PRE;
        // R13 R14 read write
        // write strobe high picks a read
        3'h5:    cmd_nxt = SDCAD_READ;
        // write strobe low picks a write
        3'h4:    cmd_nxt = SDCAD_WRITE;
        // all three strobes low load the mode op-code
        3'h0:    cmd_nxt = SDCAD_MODE;
        // all strobes high is a no-operation
        3'h7:    cmd_nxt = SDCAD_NOP;
        // codes outside this block's scope are flagged but change nothing
        default: cmd_nxt = SDCAD_OTHER;  // refresh, burst stop
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  // R1 rising edge sampling
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      // quiet decode: no pulse and cleared fields
      o_cmd_vld  <= 1'b0;
      o_cmd      <= SDCAD_NOP;
      o_bank     <= '0;
      o_row      <= '0;
      o_col      <= '0;
      o_auto_pre <= 1'b0;
      o_pre_all  <= 1'b0;
    end
    else
    begin
      // any decoded command other than a no-operation pulses valid
      o_cmd_vld  <= (cmd_nxt != SDCAD_NOP);
      o_cmd      <= cmd_nxt;
      // R2 bank capture
      o_bank     <= pins.bank_sel_lines;
      // row and column hold until the next command that loads them
      // R3 row capture
      if (cmd_nxt == SDCAD_OPEN)
        o_row <= pins.row_col_addr_lines;
      // R4 column low bits
      if (cmd_nxt == SDCAD_READ || cmd_nxt == SDCAD_WRITE)
        o_col <= pins.row_col_addr_lines[COL_W-1:0];
      // flags pulse only with the command that carries them
      // R5 auto precharge flag
      o_auto_pre <= (cmd_nxt == SDCAD_READ || cmd_nxt == SDCAD_WRITE)
                    && pins.row_col_addr_lines[FLAG_BIT];
      // R6 precharge all flag
      o_pre_all  <= (cmd_nxt == SDCAD_PRE) && pins.row_col_addr_lines[FLAG_BIT];
    end
  end

  // mode op-code load
  always_ff @(posedge i_clk)
  begin
    // op-code reads zero until the first mode set
    if (i_rst)
      o_mode_op <= '0;
    // R7 op-code load
    else if (cmd_nxt == SDCAD_MODE)
      o_mode_op <= pins.row_col_addr_lines;
  end

  // ---------------------------------------------------------------
  // per-bank state tracking
  // ---------------------------------------------------------------
  // one state machine and one pair of flags per bank
  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_bank
    logic hit;      // command names this bank
    assign hit = (pins.bank_sel_lines == BANK_W'(b));

    // bank state machine
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
      begin
        // every bank comes out of reset idle
        bst_r[b]  <= SDCAD_IDLE;
        pcnt_r[b] <= '0;
      end
      else
      begin
        unique case (bst_r[b])
          // idle: wait for an open of this bank
          // a precharge aimed at an idle bank leaves it untouched
          SDCAD_IDLE:
          begin
            // R11 activate
            if (cmd_nxt == SDCAD_OPEN && hit)
              bst_r[b] <= SDCAD_ACTIVE;
          end
          // active: wait for a precharge or an auto close
          // an open aimed at an active bank is ignored
          SDCAD_ACTIVE:
          begin
            // R6 R12 precharge one or all
            if (cmd_nxt == SDCAD_PRE && (hit || pins.row_col_addr_lines[FLAG_BIT]))
            begin
              bst_r[b]  <= SDCAD_PRECHG;
              pcnt_r[b] <= 2'(PRE_CYCLES);
            end
            // R5 self-timed close after access
            else if ((cmd_nxt == SDCAD_READ || cmd_nxt == SDCAD_WRITE) && hit
                     && pins.row_col_addr_lines[FLAG_BIT])
            begin
              bst_r[b]  <= SDCAD_PRECHG;
              pcnt_r[b] <= 2'(PRE_CYCLES);
            end
          end
          // precharging: count down, then back to idle
          SDCAD_PRECHG:
          begin
            // R12 back to idle when done
            if (pcnt_r[b] == PRE_CNT_ONE)
              bst_r[b] <= SDCAD_IDLE;
            pcnt_r[b] <= pcnt_r[b] - PRE_CNT_ONE;
          end
          // the unused code recovers to idle
          default:
            bst_r[b] <= SDCAD_IDLE;
        endcase
      end
    end

    // status flags
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
      begin
        // all banks report idle from reset
        o_bank_active[b] <= 1'b0;
        o_bank_idle[b]   <= 1'b1;
      end
      else
      begin
        // flags trail the state by one edge; precharging shows neither
        o_bank_active[b] <= (bst_r[b] == SDCAD_ACTIVE);
        o_bank_idle[b]   <= (bst_r[b] == SDCAD_IDLE);
      end
    end
  end

endmodule : sdcad_dev

// ===== hw/sdcad_pkg.sv
// command and address decode package for the four-bank synchronous memory front end
// assumes one rising-edge clock shared by controller and device ends
package sdcad_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W     = 12;           // row_col_addr_lines width
  localparam int COL_W      = 8;            // column field width
  localparam int BANK_W     = 2;            // bank_sel_lines width
  localparam int NUM_BANKS  = 4;            // internal banks
  localparam int FLAG_BIT   = 10;           // precharge_flag_line position
  localparam int PRE_CYCLES = 2;            // cycles a precharge takes to finish
  localparam logic [1:0] PRE_CNT_ONE = 2'h1; // counter decrement step

  // ---------------------------------------------------------------
  // decoded command kinds
  // ---------------------------------------------------------------
  typedef enum logic [2:0]
  {
    SDCAD_NOP     = 3'h0,
    SDCAD_OPEN    = 3'h1,   // open_row_cmd
    SDCAD_PRE     = 3'h2,
    SDCAD_READ    = 3'h3,
    SDCAD_WRITE   = 3'h4,
    SDCAD_MODE    = 3'h5,
    SDCAD_OTHER   = 3'h6
  } sdcad_cmd_t;

  // per-bank state, gray along idle -> active -> precharging
  typedef enum logic [1:0]
  {
    SDCAD_IDLE    = 2'h0,
    SDCAD_ACTIVE  = 2'h1,
    SDCAD_PRECHG  = 2'h3
  } sdcad_bank_t;

endpackage : sdcad_pkg

// ===== hw/sdcad_if.sv
// pin-level carrier between controller end and device end
// assumes both ends sample on the same i_clk rising edge
`timescale 1ns/1ns
interface sdcad_if;
  import sdcad_pkg::*;

  logic                  sel_n;          // device select, active low
  logic                  row_stb_n;      // row strobe, active low
  logic                  col_stb_n;      // column strobe, active low
  logic                  wr_stb_n;       // write strobe, active low
  logic [BANK_W-1:0]     bank_sel_lines; // bank select
  logic [ADDR_W-1:0]     row_col_addr_lines; // address / op-code

  // controller drives everything
  modport ctrl (output sel_n, row_stb_n, col_stb_n, wr_stb_n, bank_sel_lines,
                output row_col_addr_lines);
  // device samples everything
  modport dev  (input sel_n, row_stb_n, col_stb_n, wr_stb_n, bank_sel_lines,
                input row_col_addr_lines);
endinterface : sdcad_if

// ===== hw/sdcad_ctrl.sv
// controller end: turns one-cycle user requests into pin commands
// assumes the user keeps bank ordering (open before access)
`timescale 1ns/1ns
module sdcad_ctrl
  import sdcad_pkg::*;
(
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // user request
  input  wire logic                  i_req,
  input  sdcad_cmd_t                 i_cmd,
  input  wire logic                  i_dev_en,   // this device selected
  input  wire logic [BANK_W-1:0]     i_bank,
  input  wire logic [ADDR_W-1:0]     i_addr,     // row or op-code
  input  wire logic [COL_W-1:0]      i_col,
  input  wire logic                  i_flag,     // auto or all precharge
  // pins to device
  sdcad_if.ctrl                      pins
);

  // ---------------------------------------------------------------
  // pin drive, registered
  // ---------------------------------------------------------------
  logic [2:0]        stb_nxt;   // row, column, write strobes
  logic [ADDR_W-1:0] addr_nxt;  // address lines value

  // strobe encode
  always_comb
  begin
    stb_nxt  = 3'h7;
    addr_nxt = i_addr;
    unique case (i_cmd)
      SDCAD_OPEN:  stb_nxt = 3'h3;
      SDCAD_PRE:
      begin
        stb_nxt = 3'h2;
        addr_nxt[FLAG_BIT] = i_flag;
      end
      // R14 write low, read high
      SDCAD_READ, SDCAD_WRITE:
      begin
        stb_nxt = (i_cmd == SDCAD_WRITE) ? 3'h4 : 3'h5;
        // R4 R5 column and flag placement
        addr_nxt = '0;
        addr_nxt[COL_W-1:0] = i_col;
        addr_nxt[FLAG_BIT]  = i_flag;
      end
      SDCAD_MODE:  stb_nxt = 3'h0;
      default:     stb_nxt = 3'h7;
    endcase
  end

  // drive pins on each edge
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pins.sel_n              <= 1'b1;
      {pins.row_stb_n, pins.col_stb_n, pins.wr_stb_n} <= 3'h7;
      pins.bank_sel_lines     <= '0;
      pins.row_col_addr_lines <= '0;
    end
    else
    begin
      // R9 select as part of command
      pins.sel_n              <= !(i_req && i_dev_en);
      {pins.row_stb_n, pins.col_stb_n, pins.wr_stb_n} <= i_req ? stb_nxt : 3'h7;
      // R2 R3 R7 bank and address
      pins.bank_sel_lines     <= i_bank;
      pins.row_col_addr_lines <= addr_nxt;
    end
  end

endmodule : sdcad_ctrl

// ===== tb/sdcad_props.sv
// checker on the pins joining the controller end and the device end
// assumes the bench top wires it beside the interface, one clock domain
`timescale 1ns/1ns
module sdcad_props
  import sdcad_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // pins
  input  wire logic              sel_n,
  input  wire logic              row_stb_n,
  input  wire logic              col_stb_n,
  input  wire logic              wr_stb_n,
  input  wire logic [BANK_W-1:0] bank_sel_lines,
  input  wire logic [ADDR_W-1:0] row_col_addr_lines
);
  // ---------------------------------------------------------------
  // helper decode
  // ---------------------------------------------------------------
  logic [2:0]           code;    // strobes as row, column, write
  logic                 open_c;  // open command on the wire
  logic                 rw_c;    // column access on the wire
  logic                 pre_c;   // precharge on the wire
  logic [NUM_BANKS-1:0] open_r;  // banks opened by the controller
  assign code   = {row_stb_n, col_stb_n, wr_stb_n};
  assign open_c = !sel_n && (code == 3'h3);
  assign rw_c   = !sel_n && (code[2:1] == 2'h2);
  assign pre_c  = !sel_n && (code == 3'h2);
  // tracks banks opened and closed, auto precharge closing at once
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      open_r <= '0;
    else if (open_c)
      open_r[bank_sel_lines] <= 1'h1;
    else if (pre_c && row_col_addr_lines[FLAG_BIT])
      open_r <= '0;
    else if (pre_c || (rw_c && row_col_addr_lines[FLAG_BIT]))
      open_r[bank_sel_lines] <= 1'h0;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_rel_pins_quiet: assert property ($fell(i_rst) |-> sel_n && (code == 3'h7))
    else $error("pins not quiet after reset");
  a_rel_addr_zero: assert property ($fell(i_rst) |-> !(|row_col_addr_lines))
    else $error("address not zero after reset");
  a_legal_code: assert property (!sel_n |-> !(code inside {3'h1, 3'h6}))
    else $error("unlisted strobe code");
  a_col_upper_zero: assert property (rw_c |-> !row_col_addr_lines[11]
    && !(|row_col_addr_lines[9:8])) else $error("column upper bits set");
  a_rw_bank_open: assert property (rw_c |-> open_r[bank_sel_lines])
    else $error("access to closed bank");
  a_open_bank_closed: assert property (open_c |-> !open_r[bank_sel_lines])
    else $error("open of open bank");
  a_pre_bank_open: assert property (pre_c && !row_col_addr_lines[FLAG_BIT]
    |-> open_r[bank_sel_lines]) else $error("single precharge of closed bank");
  a_mode_all_idle: assert property (!sel_n && (code == 3'h0) |-> !(|open_r))
    else $error("mode set with a bank open");
endmodule : sdcad_props

// ===== tb/sdcad_tb_top.sv
// bench top joining controller end and device end through the carrier
// assumes the package, carrier and both ends compile first
`timescale 1ns/1ns
module sdcad_tb_top
  import sdcad_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic                 i_clk = 1'h0;
  logic                 i_rst = 1'h1;
  logic                 i_req = 1'h0;
  sdcad_cmd_t           i_cmd = SDCAD_NOP;
  logic                 i_dev_en = 1'h0;
  logic [BANK_W-1:0]    i_bank = '0;
  logic [ADDR_W-1:0]    i_addr = '0;
  logic [COL_W-1:0]     i_col = '0;
  logic                 i_flag = 1'h0;
  logic                 o_cmd_vld, o_auto_pre, o_pre_all;
  sdcad_cmd_t           o_cmd;
  logic [BANK_W-1:0]    o_bank;
  logic [ADDR_W-1:0]    o_row, o_mode_op;
  logic [COL_W-1:0]     o_col;
  logic [NUM_BANKS-1:0] o_bank_active, o_bank_idle;
  int                   err_count = 0;
  int                   n_compared = 0;
  always #5 i_clk = ~i_clk;
  sdcad_if link_if ();
  sdcad_ctrl sdcad_ctrl_i (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_cmd(i_cmd),
    .i_dev_en(i_dev_en), .i_bank(i_bank), .i_addr(i_addr), .i_col(i_col),
    .i_flag(i_flag), .pins(link_if.ctrl));
  sdcad_dev sdcad_dev_i (.i_clk(i_clk), .i_rst(i_rst), .pins(link_if.dev),
    .o_cmd_vld(o_cmd_vld), .o_cmd(o_cmd), .o_bank(o_bank), .o_row(o_row), .o_col(o_col),
    .o_auto_pre(o_auto_pre), .o_pre_all(o_pre_all), .o_mode_op(o_mode_op),
    .o_bank_active(o_bank_active), .o_bank_idle(o_bank_idle));
  sdcad_props sdcad_props_i (.i_clk(i_clk), .i_rst(i_rst), .sel_n(link_if.sel_n),
    .row_stb_n(link_if.row_stb_n), .col_stb_n(link_if.col_stb_n),
    .wr_stb_n(link_if.wr_stb_n), .bank_sel_lines(link_if.bank_sel_lines),
    .row_col_addr_lines(link_if.row_col_addr_lines));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // compares one value and counts it
  task automatic chk(input string what, input logic [ADDR_W-1:0] seen,
                     input logic [ADDR_W-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one request: pins checked a cycle later, decode one cycle after that
  task automatic send(input sdcad_cmd_t c, input logic en, input logic [1:0] b,
                      input logic [11:0] a, input logic [7:0] cl, input logic f);
    @(posedge i_clk);
    i_req <= 1'h1;
    i_cmd <= c;
    i_dev_en <= en;
    i_bank <= b;
    i_addr <= a;
    i_col <= cl;
    i_flag <= f;
    @(posedge i_clk);
    i_req <= 1'h0;
    #1;
    chk("select pin", link_if.sel_n, !en);
    if (en)
      chk("bank pins", link_if.bank_sel_lines, b);
    if (en && (c == SDCAD_READ || c == SDCAD_WRITE))
      chk("column pins", link_if.row_col_addr_lines, {1'h0, f, 2'h0, cl});
    @(posedge i_clk);
    #1;
    chk("valid", o_cmd_vld, en);
    if (en)
    begin
      chk("command", o_cmd, c);
      chk("bank", o_bank, b);
    end
    if (en && c == SDCAD_OPEN)
      chk("row", o_row, a);
    if (en && c == SDCAD_MODE)
      chk("op-code", o_mode_op, a);
    if (en && c == SDCAD_PRE)
      chk("all flag", o_pre_all, f);
    if (en && (c == SDCAD_READ || c == SDCAD_WRITE))
    begin
      chk("column", o_col, cl);
      chk("auto flag", o_auto_pre, f);
    end
  endtask : send
  // waits out bank timing then checks both bank flag sets
  task automatic wait_chk(input int n, input logic [3:0] act, input logic [3:0] idl);
    repeat (n) @(posedge i_clk);
    #1;
    chk("active banks", o_bank_active, act);
    chk("idle banks", o_bank_idle, idl);
  endtask : wait_chk
  // prints counts and verdict, ends the run
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'h0;
    #1;
    chk("idle at reset", o_bank_idle, 4'hF);
    send(SDCAD_MODE, 1'h1, 2'h0, 12'h5A3, 8'h00, 1'h0);
    for (int k = 0; k < 4; k++)
      send(SDCAD_OPEN, 1'h1, k[1:0], {10'h294, k[1:0]}, 8'h00, 1'h0);
    wait_chk(1, 4'hF, 4'h0);
    send(SDCAD_READ, 1'h0, 2'h1, 12'h000, 8'h77, 1'h0);
    chk("column kept", o_col, 8'h00);
    send(SDCAD_READ, 1'h1, 2'h1, 12'h000, 8'hC5, 1'h0);
    send(SDCAD_WRITE, 1'h1, 2'h2, 12'h000, 8'h3A, 1'h1);
    send(SDCAD_PRE, 1'h1, 2'h0, 12'h000, 8'h00, 1'h0);
    wait_chk(5, 4'hA, 4'h5);
    send(SDCAD_OPEN, 1'h0, 2'h0, 12'hFFF, 8'h00, 1'h0);
    chk("row kept", o_row, 12'hA53);
    send(SDCAD_PRE, 1'h0, 2'h1, 12'h000, 8'h00, 1'h1);
    wait_chk(3, 4'hA, 4'h5);
    send(SDCAD_PRE, 1'h1, 2'h1, 12'h000, 8'h00, 1'h1);
    wait_chk(5, 4'h0, 4'hF);
    close_out();
  end
  // cuts a hang short well past the expected run of about 70 cycles
  initial
  begin
    #5000;
    err_count++;
    close_out();
  end
endmodule : sdcad_tb_top
